// ---- logic/ptp_port_timing_config_regs.sv ----
// PTP port timing configuration register bank with filter, correction and egress timestamp
`timescale 1ns/10ps
`include "ptp_port_timing_consts.svh"
module ptp_port_timing_config_regs (
  // Clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      rst_b,
  input  wire logic                      ce,
  // Host bus
  input  wire logic                      host_cs,
  input  wire logic                      host_wr,
  input  wire logic                      host_rd,
  input  wire logic [11:0]               host_addr,
  input  wire logic [1:0]                host_be,
  input  wire logic [15:0]               host_wdata,
  output logic [15:0]                    host_rdata,
  output logic                           host_rvalid,
  // Received message filter
  input  wire logic                      rx_msg_valid,
  input  wire logic [3:0]                rx_msg_version,
  input  wire logic [7:0]                rx_msg_domain,
  input  wire logic                      rx_default_forward,
  output logic                           rx_msg_done,
  output logic                           rx_capture,
  output logic                           rx_drop,
  output logic                           rx_forward_host,
  // Correction field
  input  wire logic                      corr_valid,
  input  wire logic                      corr_ingress,
  input  wire logic                      corr_egress,
  input  wire ptp_port_timing_pkg::corr_t corr_in,
  output logic                           corr_out_valid,
  output ptp_port_timing_pkg::corr_t     corr_out,
  // Egress request timestamp at reference point
  input  wire logic                      tx_req_depart,
  input  wire logic [1:0]                tx_ref_sec,
  input  wire logic [29:0]               tx_ref_ns,
  // Configuration to the timing datapath
  output logic [15:0]                    cfg_rx_latency,
  output logic [15:0]                    cfg_tx_latency,
  output logic [15:0]                    cfg_link_delay,
  output logic [15:0]                    cfg_asymmetry
);
  import ptp_port_timing_pkg::*;

  localparam regs_state_t REGS_RESET = '{
    dom_en:     1'h0,
    version:    `PTP_VER_RESET,
    domain:     `PTP_DOM_RESET,
    rx_lat:     `PTP_RX_LAT_RESET,
    tx_lat:     `PTP_TX_LAT_RESET,
    asym:       `PTP_ZERO16,
    link_dly:   `PTP_ZERO16,
    ts_low:     `PTP_ZERO16,
    ts_high:    `PTP_ZERO16,
    rdata:      `PTP_ZERO16,
    rvalid:     1'h0,
    corr:       '0,
    corr_valid: 1'h0
  };

  regs_state_t state_q;
  regs_state_t state_d;

  // ----------------------------------------
  // Byte-lane merge
  // ----------------------------------------
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd, input logic [1:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // ----------------------------------------
  // Egress timestamp with transmit latency
  // ----------------------------------------
  logic [30:0] ns_sum;
  logic        ns_wrap;
  logic [29:0] ns_new;
  logic [1:0]  sec_new;

  assign ns_sum  = {1'h0, tx_ref_ns} + {15'h0, state_q.tx_lat};
  assign ns_wrap = (ns_sum >= `PTP_NS_PER_SEC);
  assign ns_new  = ns_wrap ? 30'(ns_sum - `PTP_NS_PER_SEC) : ns_sum[29:0];
  assign sec_new = ns_wrap ? 2'(tx_ref_sec + `PTP_SEC_STEP) : tx_ref_sec;

  // ----------------------------------------
  // Signed asymmetry
  // ----------------------------------------
  corr_t asym_mag;
  corr_t asym_ext;

  assign asym_mag = {49'h0, state_q.asym[`PTP_ASYM_MAG_MSB:0]};
  assign asym_ext = state_q.asym[`PTP_ASYM_SIGN_BIT] ? (~asym_mag + `PTP_ONE64) : asym_mag;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [15:0] rd_word;
    rd_word = `PTP_ZERO16;
    state_d = state_q;
    state_d.rvalid = 1'h0;
    state_d.corr_valid = 1'h0;
    if (host_cs && host_wr) begin
      case (host_addr)
        `PTP_ADDR_CONTROL: begin
          if (host_be[0]) begin
            state_d.dom_en = host_wdata[`PTP_DOMAIN_EN_BIT];
          end
        end
        `PTP_ADDR_DOMAIN_VER: begin
          if (host_be[0]) begin
            state_d.domain = host_wdata[`PTP_DOM_MSB:`PTP_DOM_LSB];
          end
          if (host_be[1]) begin
            state_d.version = host_wdata[`PTP_VER_MSB:`PTP_VER_LSB];
          end
        end
        `PTP_ADDR_RX_LAT: begin
          state_d.rx_lat = merge16(state_q.rx_lat, host_wdata, host_be);
        end
        `PTP_ADDR_TX_LAT: begin
          state_d.tx_lat = merge16(state_q.tx_lat, host_wdata, host_be);
        end
        `PTP_ADDR_ASYM: begin
          state_d.asym = merge16(state_q.asym, host_wdata, host_be);
        end
        `PTP_ADDR_LINK_DLY: begin
          state_d.link_dly = merge16(state_q.link_dly, host_wdata, host_be);
        end
        `PTP_ADDR_TS_LOW: begin
          state_d.ts_low = merge16(state_q.ts_low, host_wdata, host_be);
        end
        `PTP_ADDR_TS_HIGH: begin
          state_d.ts_high = merge16(state_q.ts_high, host_wdata, host_be);
        end
        default: begin
        end
      endcase
    end
    // Departure capture wins over a host write in the same cycle
    if (tx_req_depart) begin
      state_d.ts_low  = ns_new[`PTP_TS_NS_SPLIT-1:0];
      state_d.ts_high = {sec_new, ns_new[`PTP_TS_NS_MSB:`PTP_TS_NS_SPLIT]};
    end
    if (host_cs && host_rd) begin
      case (host_addr)
        `PTP_ADDR_CONTROL: begin
          rd_word[`PTP_DOMAIN_EN_BIT] = state_q.dom_en;
        end
        `PTP_ADDR_DOMAIN_VER: begin
          rd_word[`PTP_VER_MSB:`PTP_VER_LSB] = state_q.version;
          rd_word[`PTP_DOM_MSB:`PTP_DOM_LSB] = state_q.domain;
        end
        `PTP_ADDR_RX_LAT: begin
          rd_word = state_q.rx_lat;
        end
        `PTP_ADDR_TX_LAT: begin
          rd_word = state_q.tx_lat;
        end
        `PTP_ADDR_ASYM: begin
          rd_word = state_q.asym;
        end
        `PTP_ADDR_LINK_DLY: begin
          rd_word = state_q.link_dly;
        end
        `PTP_ADDR_TS_LOW: begin
          rd_word = state_q.ts_low;
        end
        `PTP_ADDR_TS_HIGH: begin
          rd_word = state_q.ts_high;
        end
        default: begin
          rd_word = `PTP_ZERO16;
        end
      endcase
      state_d.rdata  = rd_word;
      state_d.rvalid = 1'h1;
    end
    if (corr_valid && (corr_ingress || corr_egress)) begin
      state_d.corr_valid = 1'h1;
      if (corr_ingress) begin
        state_d.corr = corr_in + asym_ext;
      end else begin
        state_d.corr = corr_in - asym_ext;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= REGS_RESET;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // Message filter
  // ----------------------------------------
  ptp_msg_filter u_filter (
    .ref_clk             (ref_clk),
    .rst_b               (rst_b),
    .ce                  (ce),
    .msg_valid           (rx_msg_valid),
    .msg_version         (rx_msg_version),
    .msg_domain          (rx_msg_domain),
    .default_forward     (rx_default_forward),
    .cfg_version         (state_q.version),
    .cfg_domain          (state_q.domain),
    .cfg_domain_check_en (state_q.dom_en),
    .msg_done            (rx_msg_done),
    .msg_capture         (rx_capture),
    .msg_drop            (rx_drop),
    .msg_forward         (rx_forward_host)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign host_rdata     = state_q.rdata;
  assign host_rvalid    = state_q.rvalid;
  assign corr_out       = state_q.corr;
  assign corr_out_valid = state_q.corr_valid;
  assign cfg_rx_latency = state_q.rx_lat;
  assign cfg_tx_latency = state_q.tx_lat;
  assign cfg_link_delay = state_q.link_dly;
  assign cfg_asymmetry  = state_q.asym;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_version_capture: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ce && rx_msg_valid && (rx_msg_version == state_q.version) |=> rx_capture && !rx_drop)
    else $error("matching version not captured");

  chk_version_drop: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ce && rx_msg_valid && (rx_msg_version != state_q.version) |=> rx_drop && !rx_capture && !rx_forward_host)
    else $error("mismatching version not dropped");

  chk_domain_filter: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ce && rx_msg_valid && state_q.dom_en && (rx_msg_version == state_q.version)
    |=> rx_forward_host == $past(rx_msg_domain == state_q.domain))
    else $error("domain filter decision wrong");

  chk_domain_ignore: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ce && rx_msg_valid && !state_q.dom_en && (rx_msg_version == state_q.version)
    |=> rx_forward_host == $past(rx_default_forward))
    else $error("default forwarding not followed");

  chk_domain_en_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ce && host_cs && host_wr && host_be[0] && (host_addr == `PTP_ADDR_CONTROL)
    |=> state_q.dom_en == $past(host_wdata[`PTP_DOMAIN_EN_BIT]))
    else $error("domain enable not written");

  chk_rx_lat_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ce && host_cs && host_wr && (host_be == 2'h3) && (host_addr == `PTP_ADDR_RX_LAT)
    |=> cfg_rx_latency == $past(host_wdata))
    else $error("receive latency not written");

  chk_ingress_add: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ce && corr_valid && corr_ingress |=> corr_out_valid && (corr_out == $past(corr_in) + $past(asym_ext)))
    else $error("ingress correction wrong");

  chk_egress_sub: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ce && corr_valid && corr_egress && !corr_ingress
    |=> corr_out_valid && (corr_out == $past(corr_in) - $past(asym_ext)))
    else $error("egress correction wrong");

  chk_ts_coherent: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ce && tx_req_depart |=> (state_q.ts_low == $past(ns_new[`PTP_TS_NS_SPLIT-1:0]))
    && (state_q.ts_high == {$past(sec_new), $past(ns_new[`PTP_TS_NS_MSB:`PTP_TS_NS_SPLIT])}))
    else $error("egress timestamp not loaded coherently");

  chk_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ce && host_cs && host_rd && (host_addr == `PTP_ADDR_DOMAIN_VER)
    |=> host_rvalid && (host_rdata[15:12] == 4'h0))
    else $error("reserved bits not zero");

  cov_drop: cover property (@(posedge ref_clk) disable iff (!rst_b) rx_msg_done && rx_drop);
  cov_domain_fwd: cover property (@(posedge ref_clk) disable iff (!rst_b) rx_forward_host && state_q.dom_en);
  cov_ts_wrap: cover property (@(posedge ref_clk) disable iff (!rst_b) ce && tx_req_depart && ns_wrap);
  cov_neg_asym: cover property (@(posedge ref_clk) disable iff (!rst_b)
    corr_out_valid && state_q.asym[`PTP_ASYM_SIGN_BIT]);
endmodule

// ---- logic/ptp_port_timing_consts.svh ----
// Register offsets, field positions, reset values and timing constants
`ifndef PTP_PORT_TIMING_CONSTS_SVH
`define PTP_PORT_TIMING_CONSTS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PTP_ADDR_CONTROL    12'h620
`define PTP_ADDR_DOMAIN_VER 12'h624
`define PTP_ADDR_RX_LAT     12'h640
`define PTP_ADDR_TX_LAT     12'h642
`define PTP_ADDR_ASYM       12'h644
`define PTP_ADDR_LINK_DLY   12'h646
`define PTP_ADDR_TS_LOW     12'h648
`define PTP_ADDR_TS_HIGH    12'h64A
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PTP_DOMAIN_EN_BIT   4
`define PTP_VER_MSB         11
`define PTP_VER_LSB         8
`define PTP_DOM_MSB         7
`define PTP_DOM_LSB         0
`define PTP_ASYM_SIGN_BIT   15
`define PTP_ASYM_MAG_MSB    14
`define PTP_TSH_SEC_MSB     15
`define PTP_TSH_SEC_LSB     14
`define PTP_TSH_NS_MSB      13
`define PTP_TS_NS_SPLIT     16
`define PTP_TS_NS_MSB       29
// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define PTP_VER_RESET       4'h2
`define PTP_DOM_RESET       8'h00
`define PTP_RX_LAT_RESET    16'h019F
`define PTP_TX_LAT_RESET    16'h002D
`define PTP_ZERO16          16'h0000
`define PTP_NS_PER_SEC      31'h3B9ACA00
`define PTP_SEC_STEP        2'h1
`define PTP_ONE64           64'h1
`endif

// ---- logic/ptp_port_timing_pkg.sv ----
// Types shared by the PTP port timing register bank
package ptp_port_timing_pkg;
  typedef logic [63:0] corr_t;

  typedef struct packed {
    logic        dom_en;
    logic [3:0]  version;
    logic [7:0]  domain;
    logic [15:0] rx_lat;
    logic [15:0] tx_lat;
    logic [15:0] asym;
    logic [15:0] link_dly;
    logic [15:0] ts_low;
    logic [15:0] ts_high;
    logic [15:0] rdata;
    logic        rvalid;
    corr_t       corr;
    logic        corr_valid;
  } regs_state_t;

  typedef struct packed {
    logic done;
    logic capture;
    logic drop;
    logic forward;
  } filter_state_t;
endpackage

// ---- logic/ptp_msg_filter.sv ----
// Received PTP message version and domain filter
`timescale 1ns/10ps
module ptp_msg_filter (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  // Message header
  input  wire logic       msg_valid,
  input  wire logic [3:0] msg_version,
  input  wire logic [7:0] msg_domain,
  input  wire logic       default_forward,
  // Configuration
  input  wire logic [3:0] cfg_version,
  input  wire logic [7:0] cfg_domain,
  input  wire logic       cfg_domain_check_en,
  // Decision
  output logic            msg_done,
  output logic            msg_capture,
  output logic            msg_drop,
  output logic            msg_forward
);
  import ptp_port_timing_pkg::*;

  filter_state_t state_q;
  filter_state_t state_d;
  logic          ver_ok;
  logic          dom_ok;

  assign ver_ok = (msg_version == cfg_version);
  assign dom_ok = (msg_domain == cfg_domain);

  always_comb begin
    state_d = state_q;
    state_d.done = msg_valid;
    if (msg_valid) begin
      state_d.capture = ver_ok;
      state_d.drop    = !ver_ok;
      if (cfg_domain_check_en) begin
        state_d.forward = ver_ok && dom_ok;
      end else begin
        state_d.forward = ver_ok && default_forward;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= '0;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  assign msg_done    = state_q.done;
  assign msg_capture = state_q.capture;
  assign msg_drop    = state_q.drop;
  assign msg_forward = state_q.forward;
endmodule

// ---- testbench/ptp_port_timing_config_regs_tb.sv ----
// Self-checking testbench for the PTP port timing register bank
`timescale 1ns/10ps
module ptp_port_timing_config_regs_tb;
  import ptp_port_timing_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        ref_clk, rst_b, ce;
  logic        host_cs, host_wr, host_rd;
  logic [11:0] host_addr;
  logic [1:0]  host_be;
  logic [15:0] host_wdata, host_rdata;
  logic        host_rvalid;
  logic        rx_msg_valid, rx_default_forward;
  logic [3:0]  rx_msg_version;
  logic [7:0]  rx_msg_domain;
  logic        rx_msg_done, rx_capture, rx_drop, rx_forward_host;
  logic        corr_valid, corr_ingress, corr_egress, corr_out_valid;
  corr_t       corr_in, corr_out;
  logic        tx_req_depart;
  logic [1:0]  tx_ref_sec;
  logic [29:0] tx_ref_ns;
  logic [15:0] cfg_rx_latency, cfg_tx_latency, cfg_link_delay, cfg_asymmetry;
  int          fail_count = 0;
  int          checks_done = 0;

  typedef struct packed {
    logic [11:0] addr;
    logic [1:0]  be;
    logic [15:0] wdata;
    logic [15:0] exp;
  } row_t;

  row_t rows [11] = '{
    '{12'h620, 2'h3, 16'hFFFF, 16'h0010},
    '{12'h624, 2'h3, 16'hFFFF, 16'h0FFF},
    '{12'h624, 2'h1, 16'h1234, 16'h0F34},
    '{12'h624, 2'h3, 16'h0305, 16'h0305},
    '{12'h640, 2'h3, 16'hABCD, 16'hABCD},
    '{12'h642, 2'h3, 16'h0064, 16'h0064},
    '{12'h644, 2'h3, 16'h8010, 16'h8010},
    '{12'h646, 2'h2, 16'h5AA5, 16'h5A00},
    '{12'h648, 2'h3, 16'h1357, 16'h1357},
    '{12'h64A, 2'h3, 16'hC001, 16'hC001},
    '{12'h626, 2'h3, 16'hFFFF, 16'h0000}
  };

  ptp_port_timing_config_regs uut (
    .ref_clk(ref_clk), .rst_b(rst_b), .ce(ce),
    .host_cs(host_cs), .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
    .host_be(host_be), .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
    .rx_msg_valid(rx_msg_valid), .rx_msg_version(rx_msg_version), .rx_msg_domain(rx_msg_domain),
    .rx_default_forward(rx_default_forward), .rx_msg_done(rx_msg_done), .rx_capture(rx_capture),
    .rx_drop(rx_drop), .rx_forward_host(rx_forward_host),
    .corr_valid(corr_valid), .corr_ingress(corr_ingress), .corr_egress(corr_egress),
    .corr_in(corr_in), .corr_out_valid(corr_out_valid), .corr_out(corr_out),
    .tx_req_depart(tx_req_depart), .tx_ref_sec(tx_ref_sec), .tx_ref_ns(tx_ref_ns),
    .cfg_rx_latency(cfg_rx_latency), .cfg_tx_latency(cfg_tx_latency),
    .cfg_link_delay(cfg_link_delay), .cfg_asymmetry(cfg_asymmetry)
  );

  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (2000) @(posedge ref_clk);
    fail_count++;
    close_out();
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic close_out();
    if (fail_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [1:0] be, input logic [15:0] d);
    @(negedge ref_clk);
    host_cs = 1'h1; host_wr = 1'h1; host_addr = a; host_be = be; host_wdata = d;
    @(negedge ref_clk);
    host_cs = 1'h0; host_wr = 1'h0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    @(negedge ref_clk);
    host_cs = 1'h1; host_rd = 1'h1; host_addr = a;
    @(negedge ref_clk);
    chk("read valid", 64'h1, 64'(host_rvalid));
    d = host_rdata;
    host_cs = 1'h0; host_rd = 1'h0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    chk("register", 64'(exp), 64'(d));
  endtask

  task automatic msg(input logic [3:0] ver, input logic [7:0] dom, input logic dfw,
                     input logic cap, input logic fwd);
    @(negedge ref_clk);
    rx_msg_valid = 1'h1; rx_msg_version = ver; rx_msg_domain = dom; rx_default_forward = dfw;
    @(negedge ref_clk);
    rx_msg_valid = 1'h0;
    chk("msg done", 64'h1, 64'(rx_msg_done));
    chk("capture", 64'(cap), 64'(rx_capture));
    chk("drop", 64'(!cap), 64'(rx_drop));
    chk("forward", 64'(fwd), 64'(rx_forward_host));
  endtask

  task automatic corr(input logic ing, input logic eg, input corr_t cin, input corr_t exp);
    @(negedge ref_clk);
    corr_valid = 1'h1; corr_ingress = ing; corr_egress = eg; corr_in = cin;
    @(negedge ref_clk);
    corr_valid = 1'h0;
    chk("corr valid", 64'h1, 64'(corr_out_valid));
    chk("corr out", exp, corr_out);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_b = 1'h0; ce = 1'h1; host_cs = 1'h0; host_wr = 1'h0; host_rd = 1'h0;
    host_addr = 12'h000; host_be = 2'h0; host_wdata = 16'h0000;
    rx_msg_valid = 1'h0; rx_msg_version = 4'h0; rx_msg_domain = 8'h00; rx_default_forward = 1'h0;
    corr_valid = 1'h0; corr_ingress = 1'h0; corr_egress = 1'h0; corr_in = 64'h0;
    tx_req_depart = 1'h0; tx_ref_sec = 2'h0; tx_ref_ns = 30'h0;
    repeat (3) @(negedge ref_clk);
    rst_b = 1'h1;
    rd_chk(12'h624, 16'h0200);
    rd_chk(12'h640, 16'h019F);
    rd_chk(12'h642, 16'h002D);
    rd_chk(12'h644, 16'h0000);
    rd_chk(12'h646, 16'h0000);
    rd_chk(12'h648, 16'h0000);
    rd_chk(12'h64A, 16'h0000);
    rd_chk(12'h620, 16'h0000);
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].be, rows[i].wdata);
      rd_chk(rows[i].addr, rows[i].exp);
    end
    chk("cfg", 64'hABCD_0064_5A00_8010,
        64'({cfg_rx_latency, cfg_tx_latency, cfg_link_delay, cfg_asymmetry}));
    // ----------------------------------------
    // Filter with domain check on, then off
    // ----------------------------------------
    msg(4'h3, 8'h05, 1'h0, 1'h1, 1'h1);
    msg(4'h2, 8'h05, 1'h1, 1'h0, 1'h0);
    msg(4'h3, 8'h06, 1'h1, 1'h1, 1'h0);
    wr(12'h620, 2'h3, 16'h0000);
    msg(4'h3, 8'h06, 1'h1, 1'h1, 1'h1);
    msg(4'h3, 8'h05, 1'h0, 1'h1, 1'h0);
    // ----------------------------------------
    // Correction, asymmetry minus 16 then others
    // ----------------------------------------
    corr(1'h1, 1'h0, 64'h3E8, 64'h3D8);
    corr(1'h0, 1'h1, 64'h3E8, 64'h3F8);
    corr(1'h1, 1'h1, 64'h3E8, 64'h3D8);
    corr(1'h1, 1'h0, 64'hFFFF_FFFF_FFFF_FFFB, 64'hFFFF_FFFF_FFFF_FFEB);
    wr(12'h644, 2'h3, 16'h0005);
    corr(1'h0, 1'h1, 64'hA, 64'h5);
    wr(12'h644, 2'h3, 16'h8000);
    corr(1'h1, 1'h0, 64'hA, 64'hA);
    // ----------------------------------------
    // Egress timestamp, second wrap and write collision
    // ----------------------------------------
    @(negedge ref_clk);
    tx_req_depart = 1'h1; tx_ref_sec = 2'h3; tx_ref_ns = 30'h3B9A_C9CE;
    @(negedge ref_clk);
    tx_req_depart = 1'h0;
    rd_chk(12'h648, 16'h0032);
    rd_chk(12'h64A, 16'h0000);
    @(negedge ref_clk);
    tx_req_depart = 1'h1; tx_ref_sec = 2'h1; tx_ref_ns = 30'h0001_2345;
    host_cs = 1'h1; host_wr = 1'h1; host_addr = 12'h648; host_be = 2'h3; host_wdata = 16'hFFFF;
    @(negedge ref_clk);
    tx_req_depart = 1'h0; host_cs = 1'h0; host_wr = 1'h0;
    rd_chk(12'h648, 16'h23A9);
    rd_chk(12'h64A, 16'h4001);
    // ----------------------------------------
    // Clock enable low and second reset
    // ----------------------------------------
    ce = 1'h0;
    wr(12'h646, 2'h3, 16'h1111);
    ce = 1'h1;
    rd_chk(12'h646, 16'h5A00);
    @(negedge ref_clk);
    chk("read valid end", 64'h0, 64'(host_rvalid));
    rst_b = 1'h0;
    #1;
    chk("cfg reset", 64'h019F_002D_0000_0000,
        64'({cfg_rx_latency, cfg_tx_latency, cfg_link_delay, cfg_asymmetry}));
    @(negedge ref_clk);
    rst_b = 1'h1;
    rd_chk(12'h624, 16'h0200);
    rd_chk(12'h64A, 16'h0000);
    close_out();
  end
endmodule
